// File: rtl/irp_top.sv
// Interrupt request latching, priority selection and APB register file.
// Assumes sources and ack come from logic on clk_i; port C pins are
// asynchronous and are synchronised here.

`timescale 1ns/100ps
`default_nettype none

module irp_top
  import irp_pkg::*;
(
  input  wire logic        clk_i,         // System clock
  input  wire logic        nrst_i,        // Synchronous reset, low
  input  wire logic [15:0] paddr_i,       // APB address
  input  wire logic        psel_i,        // APB select
  input  wire logic        penable_i,     // APB enable
  input  wire logic        pwrite_i,      // APB direction
  input  wire logic [31:0] pwdata_i,      // APB write data
  output logic      [31:0] prdata_o,      // APB read data
  output logic             pready_o,      // APB ready
  output logic             pslverr_o,     // APB error
  input  wire logic [7:0]  g0_src_i,      // First group requests
  input  wire logic [3:0]  pc_pin_i,      // Port C pins
  input  wire logic        wdt_timeout_i, // Watchdog time-out pulse
  input  wire logic        irq_ack_i,     // Core takes presented request
  output logic             irq_req_o,     // Request to the core
  output logic      [3:0]  irq_src_o,     // Presented source id
  output logic      [1:0]  irq_level_o,   // Presented level
  output logic             wdt_reset_o,   // Watchdog system reset
  output logic             int_o          // Event interrupt
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0]  g0_pend_r;   // First group pending bits
  logic [7:0]  g0_pend_nxt;
  logic [7:0]  prio_hi_r;   // Priority high enable bits
  logic [7:0]  prio_lo_r;   // Priority low enable bits
  logic [3:0]  pc_en_r;     // Port C enables
  logic [3:0]  pc_pend_r;   // Port C pending bits
  logic [3:0]  pc_pend_nxt;
  logic [2:0]  ctrl_r;      // Enable, watchdog select, watchdog pending
  logic [2:0]  ctrl_nxt;
  logic [2:0]  stat_r;      // Sticky events
  logic [2:0]  stat_nxt;
  logic [2:0]  mask_r;      // Event mask
  logic [2:0]  ev;          // Events this cycle
  logic [3:0]  pc_s1_r;     // Synchroniser first stage
  logic [3:0]  pc_s2_r;     // Second stage
  logic [3:0]  pc_s3_r;     // Third stage
  logic [3:0]  pc_filt_r;   // Accepted pin level
  logic [3:0]  pc_rise;     // Accepted rising edges
  logic [12:0] pend_all;    // Pending bits, by source id
  logic [1:0]  lvl [N_SRC]; // Level of each source
  logic        best_valid;  // Some source can be presented
  logic [3:0]  best_src;    // Chosen source
  logic [1:0]  best_lvl;    // Its level
  logic        ack_hit;     // Acknowledge of a live request
  logic        setup;       // APB setup cycle
  logic        wr_done;     // APB write completes
  logic        rd_done;     // APB read completes
  logic [11:0] idx;         // Word index of the address
  logic        hit;         // Address is mapped
  logic [31:0] rd_mux;      // Read data selection
  logic [2:0]  stat_snap_r; // Status bits returned by the read
  logic [11:0] idx_r;       // Index held from setup

  ////////////////////////////////////////////////////////////////////////
  // APB decode

  assign setup   = psel_i & ~penable_i;
  assign wr_done = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
  assign rd_done = psel_i & penable_i & pready_o & ~pwrite_i & ~pslverr_o;
  assign idx     = paddr_i[13:2];

  // Mapped address check, word aligned only
  always_comb begin
    hit = 1'b0;
    if (paddr_i[15:14] == 2'b00 && paddr_i[1:0] == 2'b00) begin
      unique case (idx)
        IDX_G0_REQ, IDX_PRIO_HI, IDX_PRIO_LO, IDX_PC_EN, IDX_CTRL,
        IDX_VECTOR, IDX_PC_REQ, IDX_STAT, IDX_MASK: hit = 1'b1;
        default:                                   hit = 1'b0;
      endcase
    end
  end

  // Read data selection, unused upper bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      IDX_G0_REQ:  rd_mux[7:0] = g0_pend_r;
      IDX_PRIO_HI: rd_mux[7:0] = prio_hi_r;
      IDX_PRIO_LO: rd_mux[7:0] = prio_lo_r;
      IDX_PC_EN:   rd_mux[3:0] = pc_en_r;
      IDX_CTRL:    rd_mux[2:0] = ctrl_r;
      IDX_VECTOR:  rd_mux[6:0] = {irq_req_o, irq_level_o, irq_src_o};
      IDX_PC_REQ:  rd_mux[3:0] = pc_pend_r; // R05
      IDX_STAT:    rd_mux[2:0] = stat_r;
      IDX_MASK:    rd_mux[2:0] = mask_r;
      default:     rd_mux      = 32'h0000_0000;
    endcase
  end

  // Answer one cycle after setup; data sampled at setup
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pready_o    <= 1'b0;
      pslverr_o   <= 1'b0;
      prdata_o    <= 32'h0000_0000;
      stat_snap_r <= RST_EV;
      idx_r       <= 12'h000;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~hit;
      if (setup) begin
        prdata_o    <= hit ? rd_mux : 32'h0000_0000;
        stat_snap_r <= stat_r;
        idx_r       <= idx;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Priority enables, one bit pair per first group request
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      prio_hi_r <= RST_PRIO;
      prio_lo_r <= RST_PRIO;
    end else if (wr_done && idx_r == IDX_PRIO_HI) begin
      prio_hi_r <= pwdata_i[7:0]; // R08
    end else if (wr_done && idx_r == IDX_PRIO_LO) begin
      prio_lo_r <= pwdata_i[7:0]; // R08
    end
  end

  // Port C enables and event mask
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pc_en_r <= RST_PC;
      mask_r  <= RST_EV;
    end else if (wr_done && idx_r == IDX_PC_EN) begin
      pc_en_r <= pwdata_i[3:0];
    end else if (wr_done && idx_r == IDX_MASK) begin
      mask_r <= pwdata_i[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port C pin synchroniser and edge detect

  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pc_s1_r   <= 4'h0;
      pc_s2_r   <= 4'h0;
      pc_s3_r   <= 4'h0;
      pc_filt_r <= 4'h0;
    end else begin
      pc_s1_r <= pc_pin_i;
      pc_s2_r <= pc_s1_r;
      pc_s3_r <= pc_s2_r;
      for (int k = 0; k < N_PC; k++) begin
        if (pc_s2_r[k] == pc_s3_r[k]) begin
          pc_filt_r[k] <= pc_s3_r[k];
        end
      end
    end
  end

  // Rising edge of accepted level
  always_comb begin
    pc_rise = 4'h0;
    for (int k = 0; k < N_PC; k++) begin
      pc_rise[k] = (pc_s2_r[k] == pc_s3_r[k]) & pc_s3_r[k] & ~pc_filt_r[k];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending request latches

  assign ack_hit = irq_ack_i & irq_req_o;

  // First group: write stores, ack clears, new request wins
  always_comb begin
    g0_pend_nxt = g0_pend_r;
    if (wr_done && idx_r == IDX_G0_REQ) begin
      g0_pend_nxt = pwdata_i[7:0];
    end
    if (ack_hit && irq_src_o < SRC_PC0) begin
      g0_pend_nxt[irq_src_o[2:0]] = 1'b0;
    end
    g0_pend_nxt = g0_pend_nxt | g0_src_i; // R01
  end

  // Port C: upper bits are not stored and read zero
  always_comb begin
    pc_pend_nxt = pc_pend_r;
    if (wr_done && idx_r == IDX_PC_REQ) begin
      pc_pend_nxt = pwdata_i[3:0]; // R05
    end
    if (ack_hit && irq_src_o >= SRC_PC0 && irq_src_o < SRC_WDT) begin
      pc_pend_nxt[irq_src_o[1:0]] = 1'b0;
    end
    pc_pend_nxt = pc_pend_nxt | pc_rise; // R04
  end

  // Control: enable and select written, watchdog pending set by time-out with option 0
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_done && idx_r == IDX_CTRL) begin
      ctrl_nxt = pwdata_i[2:0];
    end
    if (ack_hit && irq_src_o == SRC_WDT) begin
      ctrl_nxt[CTL_WDT_PND] = 1'b0;
    end
    if (wdt_timeout_i && !ctrl_r[CTL_WDT_SEL]) begin
      ctrl_nxt[CTL_WDT_PND] = 1'b1; // R09
    end
  end

  // Pending register updates
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      g0_pend_r <= RST_G0_REQ;
      pc_pend_r <= RST_PC;
      ctrl_r    <= RST_CTRL;
    end else begin
      g0_pend_r <= g0_pend_nxt;
      pc_pend_r <= pc_pend_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  // Watchdog reset when the option bit is unprogrammed
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wdt_reset_o <= 1'b0;
    end else begin
      wdt_reset_o <= wdt_timeout_i & ctrl_r[CTL_WDT_SEL]; // R09
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Priority selection

  // Level per source
  always_comb begin
    for (int i = 0; i < N_G0; i++) begin
      lvl[i] = {prio_hi_r[i], prio_lo_r[i]}; // R06 R07
    end
    for (int k = 0; k < N_PC; k++) begin
      lvl[N_G0 + k] = pc_en_r[k] ? LVL_1 : LVL_OFF;
    end
    lvl[SRC_WDT] = LVL_3;
  end

  assign pend_all = {ctrl_r[CTL_WDT_PND], pc_pend_r, g0_pend_r};

  // Highest level wins, lowest id breaks a tie
  always_comb begin
    best_valid = 1'b0;
    best_src   = 4'h0;
    best_lvl   = LVL_OFF;
    for (int i = 0; i < N_SRC; i++) begin
      if (pend_all[i] && lvl[i] > best_lvl) begin // R06 R10
        best_valid = 1'b1;
        best_src   = 4'(i);
        best_lvl   = lvl[i];
      end
    end
  end

  // Request to core, only while globally enabled
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_req_o   <= 1'b0;
      irq_src_o   <= 4'h0;
      irq_level_o <= LVL_OFF;
    end else begin
      irq_req_o   <= best_valid & ctrl_r[CTL_GIE] & ~ack_hit; // R02 R03
      irq_src_o   <= best_src;   // R10
      irq_level_o <= best_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event status and interrupt output

  assign ev[EV_G0]  = |(g0_src_i & ~g0_pend_r);
  assign ev[EV_PC]  = |pc_rise;
  assign ev[EV_WDT] = wdt_timeout_i;

  // Read clears only bits returned, new events win
  always_comb begin
    stat_nxt = stat_r;
    if (rd_done && idx_r == IDX_STAT) begin
      stat_nxt = stat_nxt & ~stat_snap_r;
    end
    stat_nxt = stat_nxt | ev;
  end

  // Status register and interrupt level, a new mask counts at once
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      stat_r <= RST_EV;
      int_o  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      int_o  <= |(stat_nxt & (wr_done && idx_r == IDX_MASK ?
                              pwdata_i[2:0] : mask_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // APB access phase is answered once
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_one_ready;
    pready_o ##1 !pready_o;
  endsequence
  a_apb_ready: assert property (s_setup |=> s_one_ready)
    else $error("APB ready not a single cycle after setup");
  a_pend_set: assert property ( // R01
    |g0_src_i |=> (g0_pend_r & $past(g0_src_i)) == $past(g0_src_i))
    else $error("First group request not latched");
  a_pc_latch: assert property ( // R04
    |pc_rise |=> (pc_pend_r & $past(pc_rise)) == $past(pc_rise))
    else $error("Port C request not latched");
  a_pc_upper: assert property ( // R05
    (s_setup and idx == IDX_PC_REQ) |=> prdata_o[31:4] == 28'h0)
    else $error("Port C upper bits not zero");
  a_fwd_req: assert property ( // R02
    best_valid && ctrl_r[CTL_GIE] && !ack_hit |=>
      irq_req_o && irq_level_o == $past(best_lvl))
    else $error("Enabled pending request not forwarded");
  a_poll_quiet: assert property ( // R03
    !ctrl_r[CTL_GIE] |=> !irq_req_o)
    else $error("Request raised while globally disabled");
  a_level_enc: assert property ( // R07
    best_valid && best_src < SRC_PC0 |->
      best_lvl == {prio_hi_r[best_src[2:0]], prio_lo_r[best_src[2:0]]})
    else $error("Priority level encoding wrong");
  a_no_disabled: assert property ( // R06
    irq_req_o |-> irq_level_o != LVL_OFF)
    else $error("Disabled source presented");
  a_wdt_int: assert property ( // R09
    wdt_timeout_i && !ctrl_r[CTL_WDT_SEL] |=>
      ctrl_r[CTL_WDT_PND] && !wdt_reset_o)
    else $error("Watchdog interrupt action wrong");
  a_wdt_rst: assert property ( // R09
    wdt_timeout_i && ctrl_r[CTL_WDT_SEL] |=> wdt_reset_o)
    else $error("Watchdog reset action missing");
  a_prio_max: assert property ( // R10
    pend_all[SRC_WDT] |-> best_lvl == LVL_3 && pend_all[best_src])
    else $error("Highest level not chosen");
  a_int_out: assert property (
    int_o == |(stat_r & mask_r))
    else $error("Interrupt output differs from masked status");
endmodule

`default_nettype wire

// File: common/irp_pkg.sv
// Constants, types and register map of the interrupt request block.
// Assumes a 100 MHz single clock domain and an APB register port.
//
// Summary of operation
// R01 - Any source request latches its pending bit; a watchdog time-out with option 1 resets and sets no pending bit
// R02 - Globally enabled: forward pending enabled requests
// R03 - Globally disabled: no core request, software polls
// R04 - Port C bits 3..0 flag pin requests
// R05 - Upper four port C bits stay zero
// R06 - High/low enable bits form priority; 00 off
// R07 - 01 low, 10 nominal, 11 high level
// R08 - One enable bit pair per request bit
// R09 - Watchdog option 0 interrupts, 1 resets
// R10 - Highest level presented first, fixed tie order

package irp_pkg;

  // Source counts and identifiers
  localparam int unsigned N_G0    = 8;  // First group requests
  localparam int unsigned N_PC    = 4;  // Port C pin requests
  localparam int unsigned N_SRC   = 13; // All sources
  localparam logic [3:0]  SRC_PC0 = 4'h8; // First port C source id
  localparam logic [3:0]  SRC_WDT = 4'hc; // Watchdog source id

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_G0_REQ  = 12'hfc0;
  localparam logic [11:0] IDX_PRIO_HI = 12'hfc1;
  localparam logic [11:0] IDX_PRIO_LO = 12'hfc2;
  localparam logic [11:0] IDX_PC_EN   = 12'hfc3;
  localparam logic [11:0] IDX_CTRL    = 12'hfc4;
  localparam logic [11:0] IDX_VECTOR  = 12'hfc5;
  localparam logic [11:0] IDX_PC_REQ  = 12'hfc6;
  localparam logic [11:0] IDX_STAT    = 12'hfc7;
  localparam logic [11:0] IDX_MASK    = 12'hfc8;

  // Control register field positions
  localparam int unsigned CTL_GIE     = 0; // Global interrupt enable
  localparam int unsigned CTL_WDT_SEL = 1; // Watchdog action select
  localparam int unsigned CTL_WDT_PND = 2; // Watchdog request pending

  // Event status field positions
  localparam int unsigned EV_G0  = 0; // First group request latched
  localparam int unsigned EV_PC  = 1; // Port C request latched
  localparam int unsigned EV_WDT = 2; // Watchdog time-out
  localparam int unsigned N_EV   = 3;

  // Values after reset
  localparam logic [7:0] RST_G0_REQ  = 8'h00;
  localparam logic [7:0] RST_PRIO    = 8'h00;
  localparam logic [3:0] RST_PC      = 4'h0;
  localparam logic [2:0] RST_CTRL    = 3'h2; // Watchdog bit unprogrammed
  localparam logic [2:0] RST_EV      = 3'h0;

  // Priority levels
  typedef enum logic [1:0] {
    LVL_OFF = 2'b00,
    LVL_1   = 2'b01,
    LVL_2   = 2'b10,
    LVL_3   = 2'b11
  } irp_level_e;

endpackage

// File: test/irp_core_model.sv
// Processor core model: takes each presented request with an ack pulse.
// Assumes irq_req_i is a level from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module irp_core_model (
  input  wire logic       clk_i,     // System clock
  input  wire logic       nrst_i,    // Synchronous reset, low
  input  wire logic       irq_req_i, // Presented request
  input  wire logic [3:0] delay_i,   // Cycles before taking it
  output logic            ack_o      // One-cycle take pulse
);
  ////////////////////////////////////////////////////////////////////////
  logic [3:0] wait_r; // Cycles the request has stood
  // Acks only a standing request, so nothing while polled
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !irq_req_i || ack_o) begin
      wait_r <= 4'h0;
      ack_o  <= 1'b0;
    end else if (wait_r >= delay_i) begin
      ack_o <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: test/irp_top_bench.sv
// Self-checking bench of the interrupt request block.
// Assumes one APB answer per setup and a core model that acks.
`timescale 1ns/100ps
`default_nettype none
module irp_top_bench;
  import irp_pkg::*;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  g0_src;
  logic [3:0]  pc_pin, irq_src, dly;
  logic [1:0]  irq_lvl;
  logic        wdt_to, ack, irq_req, wdt_rst, int_w;
  logic [5:0]  taken_q[$]; // Source and level at each take
  int          n_fail, total_checks, cycles;
  ////////////////////////////////////////////////////////////////////////
  irp_top u_irp_top (.clk_i(clk), .nrst_i(nrst), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .g0_src_i(g0_src), .pc_pin_i(pc_pin),
    .wdt_timeout_i(wdt_to), .irq_ack_i(ack), .irq_req_o(irq_req),
    .irq_src_o(irq_src), .irq_level_o(irq_lvl), .wdt_reset_o(wdt_rst),
    .int_o(int_w));
  irp_core_model u_irp_core_model (.clk_i(clk), .nrst_i(nrst),
    .irq_req_i(irq_req), .delay_i(dly), .ack_o(ack));
  // Records what the core took, with pre-edge values
  always @(posedge clk) begin
    if (ack && irq_req) begin
      taken_q.push_back({irq_src, irq_lvl});
    end
  end
  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("unexpected at %0t: run too long", $time);
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask
  // One APB transfer; waits for pready with psel and penable high
  task automatic apb(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) chk(32'h0, 32'h1, "apb wait");
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, v, d, e);
  endtask
  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] v,
                        input string what);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 32'h0, d, e);
    chk(d, v, what);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse_g0(input logic [7:0] m);
    @(posedge clk);
    g0_src <= m;
    @(posedge clk);
    g0_src <= 8'h00;
  endtask
  // Counts watchdog reset pulses after one time-out pulse
  task automatic wdt_pulse(output int n);
    n = 0;
    @(posedge clk);
    wdt_to <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    repeat (4) begin
      @(negedge clk);
      n += wdt_rst;
    end
  endtask
  // Waits for the next take and compares source and level
  task automatic take(input logic [3:0] s, input logic [1:0] l);
    int n;
    n = 0;
    while (taken_q.size() == 0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (taken_q.size() == 0) begin
      chk(32'h0, 32'h1, "no take");
    end else begin
      chk({26'h0, taken_q.pop_front()}, {26'h0, s, l}, "take");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] d;
    logic        e;
    rd_chk(IDX_PC_REQ, 32'h0, "pc pend reset");
    rd_chk(IDX_G0_REQ, 32'h0, "g0 pend reset");
    rd_chk(IDX_CTRL, 32'h2, "ctrl reset");
    apb(1'b0, 12'hfc9, 32'h0, d, e);
    chk({31'h0, e}, 32'h1, "unmapped err");
    chk(d, 32'h0, "unmapped data");
    $display("reset test done");
  endtask
  task automatic t_priority;
    dly <= 4'h3;
    wr(IDX_PRIO_HI, 32'hc4);
    wr(IDX_PRIO_LO, 32'ha4);
    pulse_g0(8'he5);
    idle(5);
    chk({31'h0, irq_req}, 32'h0, "polled req");
    rd_chk(IDX_G0_REQ, 32'he5, "g0 pend");
    wr(IDX_CTRL, 32'h3);
    take(4'h2, LVL_3);
    take(4'h7, LVL_3);
    take(4'h6, LVL_2);
    take(4'h5, LVL_1);
    idle(8);
    chk({31'h0, irq_req}, 32'h0, "disabled src");
    rd_chk(IDX_G0_REQ, 32'h01, "g0 left");
    wr(IDX_CTRL, 32'h2);
    wr(IDX_G0_REQ, 32'h0);
    $display("priority test done");
  endtask
  task automatic t_portc;
    dly <= 4'h0;
    wr(IDX_PC_EN, 32'h2);
    @(posedge clk);
    pc_pin <= 4'ha;
    idle(10);
    chk({31'h0, irq_req}, 32'h0, "pc polled");
    rd_chk(IDX_PC_REQ, 32'h0a, "pc pend");
    rd_chk(IDX_VECTOR, 32'h19, "pc vector");
    wr(IDX_CTRL, 32'h3);
    take(SRC_PC0 + 4'h1, LVL_1);
    idle(6);
    chk({31'h0, irq_req}, 32'h0, "pc off pin");
    rd_chk(IDX_PC_REQ, 32'h08, "pc left");
    wr(IDX_CTRL, 32'h2);
    wr(IDX_PC_REQ, 32'h0);
    pc_pin <= 4'h0;
    $display("port c test done");
  endtask
  task automatic t_wdt;
    int n;
    wdt_pulse(n);
    chk(n, 1, "wdt reset pulse");
    wr(IDX_CTRL, 32'h1);
    wdt_pulse(n);
    chk(n, 0, "wdt no reset");
    take(SRC_WDT, LVL_3);
    wr(IDX_CTRL, 32'h2);
    $display("watchdog test done");
  endtask
  task automatic t_int;
    rd_chk(IDX_STAT, 32'h7, "status all");
    wr(IDX_MASK, 32'h1);
    pulse_g0(8'h02);
    idle(2);
    chk({31'h0, int_w}, 32'h1, "int raised");
    rd_chk(IDX_STAT, 32'h1, "status g0");
    idle(1);
    chk({31'h0, int_w}, 32'h0, "int cleared");
    @(posedge clk);
    pc_pin <= 4'h1;
    idle(8);
    chk({31'h0, int_w}, 32'h0, "int masked");
    rd_chk(IDX_STAT, 32'h2, "status pc");
    $display("interrupt test done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, psel, penable, pwrite, wdt_to} = 5'h0;
    {paddr, pwdata, g0_src, pc_pin, dly} = 64'h0;
    n_fail = 0;
    total_checks = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_priority();
    t_portc();
    t_wdt();
    t_int();
    conclude();
  end
endmodule
`default_nettype wire
